// file: design/adcbe_defines.svh
// Register map, field positions, reset values and codes of the back-end
`ifndef ADCBE_DEFINES_SVH
`define ADCBE_DEFINES_SVH
`define ADCBE_CTRL_ADDR 4'h0
`define ADCBE_GAIN_ADDR 4'h4
`define ADCBE_TCON_ADDR 4'h8
`define ADCBE_STAT_ADDR 4'hC
`define ADCBE_CTRL_MODE1 0
`define ADCBE_CTRL_MODE2 1
`define ADCBE_CTRL_LOOP_EN 2
`define ADCBE_CTRL_FREEZE 3
`define ADCBE_CTRL_PARALLEL 4
`define ADCBE_CTRL_DATA_DRV 5
`define ADCBE_CTRL_CLK_DRV 6
`define ADCBE_CTRL_FMT_LSB 8
`define ADCBE_CTRL_RESET 12'h000
`define ADCBE_GAIN_RESET 4'h0
`define ADCBE_TCON_RESET 4'h0
`define ADCBE_GAIN_MAX 4'hC
`define ADCBE_TC_MAX 4'hB
`define ADCBE_TC_BASE_SHIFT 6'h14
`define ADCBE_OFFSET_LIMIT_MV 10
`define ADCBE_FULL_SCALE_MVPP 2000
`define ADCBE_CODES 2048
`define ADCBE_OFFSET_LIMIT_CODES \
  ((`ADCBE_OFFSET_LIMIT_MV * `ADCBE_CODES) / `ADCBE_FULL_SCALE_MVPP)
`define ADCBE_OB_POS 11'h7FF
`define ADCBE_OB_NEG 11'h000
`define ADCBE_TC_POS 11'h3FF
`define ADCBE_TC_NEG 11'h400
`define ADCBE_SIGN_FLIP 11'h400
`define ADCBE_RESP_OKAY 2'h0
`define ADCBE_RESP_SLVERR 2'h2
`endif

// file: design/adcbe_pkg.sv
// Types shared by the converter back-end
package adcbe_pkg;
  typedef logic [10:0] adcbe_word_t;
  typedef logic [1:0] adcbe_resp_t;
  typedef enum logic {ADCBE_DDR, ADCBE_PARALLEL} adcbe_outmode_t;
endpackage

// file: design/adcbe_top.sv
// Converter digital back-end: gain, offset loop, format and output pins
// Operation
// (RL1) Gain 0 to 6 dB in half-dB steps
// (RL2) Gain off after reset; enable gives 0 dB
// (RL3) Offset loop removes up to 10 mV offset
// (RL4) Unfrozen loop updates and corrects every sample
// (RL5) Freeze holds estimate, still subtracts it
// (RL6) Software enables mode bits, then loop, then constant
// (RL7) Time constant code doubles from 1M cycles
// (RL8) Eleven-bit words plus one shared output clock
// (RL9) Control bit selects DDR or parallel pins
// (RL10) DDR carries two bits per pair per period
// (RL11) Separate double-drive controls for data, clock
// (RL12) Parallel mode: one bit per pin per sample
// (RL13) Receiver latches parallel words on clock rise
// (RL14) Above 150 MSPS receiver uses delayed clock
// (RL15) Per-channel two's complement or offset binary
// (RL16) Positive overdrive gives positive full-scale code
// (RL17) Negative overdrive gives negative full-scale code
// (RL18) Correct and scale before format and saturation
// (RL19) DDR: even bit on rise, odd on fall
`timescale 1ns/1ps
`include "adcbe_defines.svh"

module adcbe_top
  import adcbe_pkg::*;
(
  // System
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // AXI4-Lite register slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Converter core, sample clock domain
  input wire logic sampleClk,
  input wire logic [43:0] sampleIn,
  input wire logic [3:0] overPos,
  input wire logic [3:0] overNeg,
  // Output pins
  output logic [43:0] dataPins,
  output logic outputSampleClock,
  output logic dataBufferDoubleDrive,
  output logic clockBufferDoubleDrive
);

  localparam logic signed [10:0] OFF_LIM = 11'(`ADCBE_OFFSET_LIMIT_CODES);

  // ***************************************************************
  // Register slave
  // ***************************************************************
  logic awHeld;
  logic wHeld;
  logic [3:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  logic gainWr;
  logic [11:0] ctrl;
  logic [3:0] gainField;
  logic [3:0] tcField;
  logic gainWritten;
  logic modeEn;
  logic modeEnQ;
  logic [3:0] effGain;
  logic [2:0] statMeta;
  logic [2:0] statM;
  logic [2:0] statS;

  assign s_axi_awready = ce && !awHeld && !s_axi_bvalid;
  assign s_axi_wready = ce && !wHeld && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign doWrite = ce && awHeld && wHeld && !s_axi_bvalid;
  assign gainWr = doWrite && awAddrQ == `ADCBE_GAIN_ADDR && wStrbQ[0];
  assign modeEn = ctrl[`ADCBE_CTRL_MODE1] && ctrl[`ADCBE_CTRL_MODE2];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 4'h0;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADCBE_RESP_OKAY;
    end else if (ce) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddrQ == `ADCBE_CTRL_ADDR ||
                        awAddrQ == `ADCBE_GAIN_ADDR ||
                        awAddrQ == `ADCBE_TCON_ADDR) ?
                       `ADCBE_RESP_OKAY : `ADCBE_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ADCBE_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ADCBE_RESP_OKAY;
        case (s_axi_araddr)
          `ADCBE_CTRL_ADDR: s_axi_rdata <= {20'h0, ctrl};
          `ADCBE_GAIN_ADDR: s_axi_rdata <= {28'h0, gainField};
          `ADCBE_TCON_ADDR: s_axi_rdata <= {28'h0, tcField};
          `ADCBE_STAT_ADDR: s_axi_rdata <= {29'h0, statM};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ADCBE_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Control registers
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl <= `ADCBE_CTRL_RESET;
      tcField <= `ADCBE_TCON_RESET;
      gainField <= `ADCBE_GAIN_RESET;
    end else if (doWrite) begin
      if (awAddrQ == `ADCBE_CTRL_ADDR && wStrbQ[0]) begin
        ctrl[7:0] <= wDataQ[7:0];
      end
      if (awAddrQ == `ADCBE_CTRL_ADDR && wStrbQ[1]) begin
        ctrl[11:8] <= wDataQ[11:8];
      end
      if (awAddrQ == `ADCBE_TCON_ADDR && wStrbQ[0]) begin
        tcField <= wDataQ[3:0]; // RL7
      end
      if (gainWr) begin
        gainField <= wDataQ[3:0]; // RL1
      end
    end
  end

  // Turning the mode on forgets any earlier gain code; a write in the
  // same cycle still wins
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      modeEnQ <= 1'b0;
      gainWritten <= 1'b0;
      effGain <= 4'h0;
    end else if (ce) begin
      modeEnQ <= modeEn;
      if (gainWr) begin
        gainWritten <= 1'b1;
      end else if (modeEn && !modeEnQ) begin
        gainWritten <= 1'b0; // RL2
      end
      if (!modeEn || !gainWritten) begin
        effGain <= 4'h0; // RL2
      end else if (gainField > `ADCBE_GAIN_MAX) begin
        effGain <= `ADCBE_GAIN_MAX; // RL1
      end else begin
        effGain <= gainField;
      end
    end
  end

  assign dataBufferDoubleDrive = ctrl[`ADCBE_CTRL_DATA_DRV]; // RL11
  assign clockBufferDoubleDrive = ctrl[`ADCBE_CTRL_CLK_DRV]; // RL11

  always_ff @(posedge mclk) begin
    statMeta <= statS;
    statM <= statMeta;
  end

  property p_gainRange;
    @(posedge mclk) disable iff (!resetn) effGain <= `ADCBE_GAIN_MAX;
  endproperty
  a_gainRange: assert property (p_gainRange) // RL1
    else $error("effective gain code above 6 dB");

  property p_gainZero;
    @(posedge mclk) disable iff (!resetn)
    ce && $rose(modeEn) && !gainWr ##1 !gainWr && ce ##1 ce
    |-> effGain == 4'h0;
  endproperty
  a_gainZero: assert property (p_gainZero) // RL2
    else $error("gain not 0 dB after mode enable");

  // ***************************************************************
  // Sample domain crossing
  // ***************************************************************
  logic sResetnMeta;
  logic sResetn;
  logic sCeMeta;
  logic sCe;
  logic [14:0] cfgM;
  logic [14:0] cfgMeta;
  logic [14:0] cfgS;
  logic loopOnS;
  logic freezeS;
  logic parS;
  logic [3:0] gainS;
  logic [3:0] tcS;
  logic [3:0] fmtS;
  logic [5:0] shiftS;
  logic [11:0] gainMul;

  // Configuration is quasi-static, so a two-stage level sync is enough;
  // a word changed mid-crossing settles within two sample clocks
  assign cfgM = {ctrl[`ADCBE_CTRL_FMT_LSB +: 4], tcField, effGain,
                 ctrl[`ADCBE_CTRL_PARALLEL], ctrl[`ADCBE_CTRL_FREEZE],
                 modeEn && ctrl[`ADCBE_CTRL_LOOP_EN]};

  always_ff @(posedge sampleClk) begin
    sResetnMeta <= resetn;
    sResetn <= sResetnMeta;
    sCeMeta <= ce;
    sCe <= sCeMeta;
    cfgMeta <= cfgM;
    cfgS <= cfgMeta;
  end

  assign {fmtS, tcS, gainS, parS, freezeS, loopOnS} = cfgS;
  assign statS = {loopOnS && freezeS, loopOnS, gainS != 4'h0};
  // Reserved codes act as the longest constant
  assign shiftS = `ADCBE_TC_BASE_SHIFT +
                  {2'h0, (tcS > `ADCBE_TC_MAX) ? `ADCBE_TC_MAX : tcS}; // RL7

  always_comb begin
    case (gainS)
      4'h0: gainMul = 12'h400;
      4'h1: gainMul = 12'h43D;
      4'h2: gainMul = 12'h47D;
      4'h3: gainMul = 12'h4C1;
      4'h4: gainMul = 12'h509;
      4'h5: gainMul = 12'h556;
      4'h6: gainMul = 12'h5A7;
      4'h7: gainMul = 12'h5FC;
      4'h8: gainMul = 12'h657;
      4'h9: gainMul = 12'h6B7;
      4'hA: gainMul = 12'h71D;
      4'hB: gainMul = 12'h789;
      default: gainMul = 12'h7FB; // RL1
    endcase
  end

  // ***************************************************************
  // Per-channel datapath
  // ***************************************************************
  logic signed [42:0] acc [4];
  logic signed [42:0] accShift [4];
  logic signed [10:0] est [4];
  logic [10:0] stage1 [4];
  // One element per channel, so each channel's process owns its own
  logic ovP1 [4];
  logic ovN1 [4];
  logic [10:0] outBus [4];

  for (genvar c = 0; c < 4; c++) begin : g_chan
    logic signed [10:0] raw;
    logic signed [11:0] corr;
    logic signed [24:0] prod;
    logic signed [24:0] scaled;
    logic fmtTwos;

    assign raw = $signed(sampleIn[c*11 +: 11]);
    assign fmtTwos = fmtS[c];
    assign accShift[c] = acc[c] >>> shiftS;

    always_comb begin
      if (accShift[c] > 43'(OFF_LIM)) begin
        est[c] = OFF_LIM; // RL3
      end else if (accShift[c] < -43'(OFF_LIM)) begin
        est[c] = -OFF_LIM; // RL3
      end else begin
        est[c] = accShift[c][10:0];
      end
    end

    // Leaky integrator: time constant is two to the shift, in samples
    always_ff @(posedge sampleClk) begin
      if (!sResetn || (sCe && !loopOnS)) begin
        acc[c] <= 43'h0; // RL6
      end else if (sCe && !freezeS) begin
        acc[c] <= acc[c] + 43'(raw) - accShift[c]; // RL4
      end
    end

    // Frozen estimate keeps being subtracted
    assign corr = 12'(raw) - 12'(est[c]); // RL5
    assign prod = 25'(corr) * $signed({13'h0, gainMul}); // RL18
    assign scaled = prod >>> 10;

    always_ff @(posedge sampleClk) begin
      if (!sResetn) begin
        stage1[c] <= 11'h0;
        ovP1[c] <= 1'b0;
        ovN1[c] <= 1'b0;
      end else if (sCe) begin
        ovP1[c] <= overPos[c];
        ovN1[c] <= overNeg[c];
        if (scaled > 25'sd1023) begin
          stage1[c] <= 11'h3FF;
        end else if (scaled < -25'sd1024) begin
          stage1[c] <= 11'h400;
        end else begin
          stage1[c] <= scaled[10:0];
        end
      end
    end

    always_ff @(posedge sampleClk) begin
      if (!sResetn) begin
        outBus[c] <= 11'h0;
      end else if (sCe) begin
        if (ovP1[c]) begin
          outBus[c] <= fmtTwos ? `ADCBE_TC_POS : `ADCBE_OB_POS; // RL16
        end else if (ovN1[c]) begin
          outBus[c] <= fmtTwos ? `ADCBE_TC_NEG : `ADCBE_OB_NEG; // RL17
        end else begin
          outBus[c] <= fmtTwos ? stage1[c] :
                       stage1[c] ^ `ADCBE_SIGN_FLIP; // RL15
        end
      end
    end
  end

  // ***************************************************************
  // Output pins
  // ***************************************************************
  // Parallel clock is inverted so its rise falls mid-word
  assign outputSampleClock = parS ? ~sampleClk : sampleClk; // RL8

  always_comb begin
    dataPins = 44'h0;
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 11; j++) begin
        if (parS) begin
          dataPins[c*11 + j] = outBus[c][j]; // RL12
        end else if (sampleClk && j < 6) begin
          dataPins[c*11 + j] = outBus[c][2*j]; // RL10 RL19
        end else if (!sampleClk && j < 5) begin
          dataPins[c*11 + j] = outBus[c][2*j + 1]; // RL19
        end
      end
    end
  end

  // ***************************************************************
  // Sample-domain checks, channel 0
  // ***************************************************************
  property p_estLimit;
    @(posedge sampleClk) disable iff (!sResetn)
    est[0] <= OFF_LIM && est[0] >= -OFF_LIM;
  endproperty
  a_estLimit: assert property (p_estLimit) // RL3
    else $error("offset estimate beyond limit");

  property p_loopTrack;
    @(posedge sampleClk) disable iff (!sResetn)
    sCe && loopOnS && !freezeS &&
    43'($signed(sampleIn[10:0])) != accShift[0]
    |=> !$stable(acc[0]);
  endproperty
  a_loopTrack: assert property (p_loopTrack) // RL4
    else $error("running loop did not update");

  property p_freezeHold;
    @(posedge sampleClk) disable iff (!sResetn)
    sCe && loopOnS && freezeS |=> $stable(acc[0]);
  endproperty
  a_freezeHold: assert property (p_freezeHold) // RL5
    else $error("frozen estimate changed");

  property p_loopOff;
    @(posedge sampleClk) disable iff (!sResetn)
    sCe && !loopOnS |=> acc[0] == 43'h0;
  endproperty
  a_loopOff: assert property (p_loopOff) // RL6
    else $error("disabled loop kept an estimate");

  property p_posOver;
    @(posedge sampleClk) disable iff (!sResetn)
    sCe && overPos[0] ##1 sCe |=>
    outBus[0] == ($past(fmtS[0]) ? `ADCBE_TC_POS : `ADCBE_OB_POS);
  endproperty
  a_posOver: assert property (p_posOver) // RL16
    else $error("wrong positive overdrive code");

  property p_negOver;
    @(posedge sampleClk) disable iff (!sResetn)
    sCe && overNeg[0] && !overPos[0] ##1 sCe |=>
    outBus[0] == ($past(fmtS[0]) ? `ADCBE_TC_NEG : `ADCBE_OB_NEG);
  endproperty
  a_negOver: assert property (p_negOver) // RL17
    else $error("wrong negative overdrive code");

endmodule

// file: verification/adcbe_receiver.sv
// Logic receiver model capturing the back-end's output pins
`timescale 1ns/1ps

module adcbe_receiver (
  // Pins from the back-end
  input wire logic outputSampleClock,
  input wire logic [43:0] dataPins,
  // Receiver set-up and captured words
  input wire logic parallelMode,
  output logic [43:0] word,
  output logic gotWord
);
  // DDR data is edge-aligned, so capture mid-phase, never at the edge
  localparam int Skew = 40;

  initial begin
    word = '0;
    gotWord = 1'b0;
  end

  // At 6.25 MSPS the output clock is safe; no delayed input clock needed
  always @(posedge outputSampleClock) begin
    if (parallelMode) begin
      word = dataPins;
      gotWord = 1'b1;
      #1 gotWord = 1'b0;
    end else begin
      #Skew;
      for (int c = 0; c < 4; c++) begin
        for (int j = 0; j < 6; j++) begin
          word[c*11+2*j] = dataPins[c*11+j];
        end
      end
    end
  end

  always @(negedge outputSampleClock) begin
    if (!parallelMode) begin
      #Skew;
      for (int c = 0; c < 4; c++) begin
        for (int j = 0; j < 5; j++) begin
          word[c*11+2*j+1] = dataPins[c*11+j];
        end
      end
      gotWord = 1'b1;
      #1 gotWord = 1'b0;
    end
  end
endmodule

// file: verification/adc_digital_output_backend_test.sv
// Self-checking bench for the converter back-end
`timescale 1ns/1ps
`include "adcbe_defines.svh"

module adc_digital_output_backend_test;
  import adcbe_pkg::*;
  localparam int TimeLimit = 5000;
  logic mclk = 0, sampleClk = 0, resetn = 0, ce = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
  logic [31:0] s_axi_wdata = '0, seed = 32'h00008EA3;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_arready, s_axi_rvalid;
  wire adcbe_resp_t s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  logic [43:0] sampleIn = '0, raw;
  logic [3:0] overPos = '0, overNeg = '0, f;
  wire logic [43:0] dataPins, rxWord;
  wire logic outputSampleClock, dataBufferDoubleDrive;
  wire logic clockBufferDoubleDrive, rxGot;
  logic parallelMode = 0;
  logic [43:0] expQ[$];
  int nMismatch = 0, totalChecks = 0, cycles = 0;

  initial forever #50 mclk = ~mclk;
  initial begin
    #37;
    forever #80 sampleClk = ~sampleClk;
  end

  adcbe_top dut (
    .mclk, .resetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .sampleClk, .sampleIn, .overPos,
    .overNeg, .dataPins, .outputSampleClock, .dataBufferDoubleDrive,
    .clockBufferDoubleDrive
  );

  adcbe_receiver rx (
    .outputSampleClock, .dataPins, .parallelMode, .word(rxWord),
    .gotWord(rxGot)
  );

  task automatic check(input logic [43:0] seen, input logic [43:0] want,
                       input string what);
    totalChecks++;
    if (seen !== want) begin
      nMismatch++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what,
               seen, want);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == TimeLimit) begin
      nMismatch++;
      final_report();
    end
  end

  // Oldest noted word against the next word the receiver captures
  always @(posedge rxGot) begin
    if (expQ.size() > 0) begin
      check(rxWord, expQ.pop_front(), "output word");
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Offset binary is the two's complement word with its sign flipped
  function automatic logic [43:0] coded(input logic [43:0] v,
                                        input logic [3:0] fm);
    for (int c = 0; c < 4; c++) begin
      coded[c*11+:11] = fm[c] ? v[c*11+:11] : v[c*11+:11] ^ 11'h400;
    end
  endfunction

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           input adcbe_resp_t er);
    adcbe_resp_t r;
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    // Handshakes are judged on values sampled at the rising edge
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check(44'(r), 44'(er), "write response");
  endtask

  task automatic axi_read(input logic [3:0] a, input logic [31:0] want);
    logic [31:0] d;
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    check(44'(d), 44'(want), "register read");
  endtask

  // Hold one input set until its noted word has been compared
  task automatic stream(input logic [43:0] v, input logic [3:0] p,
                        input logic [3:0] n, input logic [43:0] want);
    @(posedge sampleClk);
    sampleIn <= v;
    overPos <= p;
    overNeg <= n;
    repeat (6) @(posedge sampleClk);
    expQ.push_back(want);
    while (expQ.size() > 0) @(posedge mclk);
  endtask

  initial begin
    // Clock phases are fixed, so two cycles still give one sample reset edge
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axi_read(4'(4 * i), 32'h0);
    end
    axi_write(`ADCBE_STAT_ADDR, 32'h7, `ADCBE_RESP_SLVERR);
    axi_write(`ADCBE_GAIN_ADDR, 32'hC, `ADCBE_RESP_OKAY);
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 3; k++) begin
        f = 4'(rnd());
        raw = 44'({rnd(), rnd()});
        axi_write(`ADCBE_CTRL_ADDR, 32'({f, 3'b000, m[0], 4'h0}),
                  `ADCBE_RESP_OKAY);
        parallelMode = m[0];
        // Mode bit needs two sample edges to cross
        repeat (3) @(posedge sampleClk);
        #1 check(44'(outputSampleClock), 44'(!m[0]), "out clock");
        stream(raw, 4'h0, 4'h0, coded(raw, f));
      end
    end
    f = 4'h5;
    axi_write(`ADCBE_CTRL_ADDR, 32'h510, `ADCBE_RESP_OKAY);
    stream(raw, 4'hF, 4'h0, coded({4{11'h3FF}}, f));
    stream(raw, 4'h0, 4'hF, coded({4{11'h400}}, f));
    stream(raw, 4'hF, 4'hF, coded({4{11'h3FF}}, f));
    parallelMode = 1'b0;
    axi_write(`ADCBE_CTRL_ADDR, 32'h503, `ADCBE_RESP_OKAY);
    stream({4{11'h258}}, 4'h0, 4'h0, coded({4{11'h258}}, f));
    axi_write(`ADCBE_GAIN_ADDR, 32'hC, `ADCBE_RESP_OKAY);
    stream({4{11'h258}}, 4'h0, 4'h0, coded({4{11'h3FF}}, f));
    stream({4{11'h5A8}}, 4'h0, 4'h0, coded({4{11'h400}}, f));
    // Quiet input before the loop starts, so the estimate begins at zero
    stream('0, 4'h0, 4'h0, coded('0, f));
    axi_write(`ADCBE_CTRL_ADDR, 32'h507, `ADCBE_RESP_OKAY);
    axi_write(`ADCBE_TCON_ADDR, 32'hB, `ADCBE_RESP_OKAY);
    axi_read(`ADCBE_TCON_ADDR, 32'hB);
    repeat (8) @(posedge mclk);
    axi_read(`ADCBE_STAT_ADDR, 32'h3);
    stream('0, 4'h0, 4'h0, coded('0, f));
    axi_write(`ADCBE_CTRL_ADDR, 32'h50F, `ADCBE_RESP_OKAY);
    stream('0, 4'h0, 4'h0, coded('0, f));
    axi_write(`ADCBE_CTRL_ADDR, 32'h20, `ADCBE_RESP_OKAY);
    check(44'({dataBufferDoubleDrive, clockBufferDoubleDrive}), 44'h2,
          "drive bits");
    axi_write(`ADCBE_CTRL_ADDR, 32'h40, `ADCBE_RESP_OKAY);
    check(44'({dataBufferDoubleDrive, clockBufferDoubleDrive}), 44'h1,
          "drive bits");
    final_report();
  end
endmodule
